// File: rtl/asp_defines.vh
// constants of the serial audio port: register offsets, fields, resets, timing
// assumes inclusion by bare name from the rtl files
`ifndef ASP_DEFINES_VH
`define ASP_DEFINES_VH
// register indices (byte address = index * 4)
`define ASP_IDX_RATE      7'h01
`define ASP_IDX_FMT       7'h54
`define ASP_IDX_MODE      7'h5a
`define ASP_IDX_CTRL      7'h70
`define ASP_IDX_STAT      7'h71
`define ASP_IDX_SAMPLE    7'h72
// reset values
`define ASP_RST_RATE      8'h50
`define ASP_RST_FMT       8'h80
`define ASP_RST_MODE      8'h03
`define ASP_RST_CTRL      8'h00
// field positions
`define ASP_FMT_MASTER    7
`define ASP_FMT_RIGHT     4
`define ASP_FMT_WSPOL     3
`define ASP_FMT_NODLY     1
`define ASP_MODE_RFEN     7
`define ASP_MODE_PDN      6
`define ASP_CTRL_RXMODE   0
`define ASP_CTRL_CFGDONE  1
// format codes of the low nibble
`define ASP_FMT_LJ        4'ha
`define ASP_FMT_I2S       4'h0
// clock control codes
`define ASP_MCLK_OFF      2'b00
`define ASP_MCLK_ON       2'b11
// 256 x 32 kHz = 8.192 MHz; 200 MHz / 8.192 MHz ~ 24, half period 12
`define ASP_CLK_HZ        200000000
`define ASP_MCLK_HZ       8192000
`define ASP_MCLK_HALF     ((`ASP_CLK_HZ / `ASP_MCLK_HZ) / 2)
// bit clock = mclk / 256; half a bit clock in mclk half periods
`define ASP_MCLK_RATIO    256
`define ASP_SLOT_BITS     32
`endif

// File: rtl/asp_fifo.v
// synchronous fifo for captured mono samples
// assumes one clock, synchronous active high reset
`timescale 1ns/10ps
module asp_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData,
    output wire [AW:0]      level
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr_r;
    reg [AW:0]      rdPtr_r;
    wire            doWr;
    wire            doRd;

    assign level    = wrPtr_r - rdPtr_r;
    assign inReady  = (level != DEPTH[AW:0]);
    assign outValid = (level != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_r[AW-1:0]];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= {(AW+1){1'b0}};
            rdPtr_r <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (doRd) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end
endmodule // asp_fifo

// File: rtl/asp_serial_port.v
// serial audio port: mclk generation, pin directions, capture of mono samples
// assumes axi4-lite master on clk; audio pins from another domain
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "asp_defines.vh"
module asp_serial_port (
    input  wire        clk,
    input  wire        rst,
    // axi4-lite slave
    input  wire [8:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [8:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // audio pins, output enables active low
    input  wire        bitClkIn,
    output reg         bitClkOut,
    output reg         bitClkOe_n,
    input  wire        wordSelIn,
    output reg         wordSelOut,
    output reg         wordSelOe_n,
    input  wire        dataIn,
    output reg         dataOut,
    output reg         dataOe_n,
    output reg         mclkOut,
    output reg         mclkOe_n,
    // radio and power controls
    output reg         rfEnable,
    output reg         txPowerDown
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg  [7:0]  rate_r;
    reg  [7:0]  fmt_r;
    reg  [7:0]  mode_r;
    reg  [7:0]  ctrl_r;
    reg         awHeld_r;
    reg         wHeld_r;
    reg  [6:0]  awIdx_r;
    reg  [31:0] wData_r;
    reg  [3:0]  wStrb_r;
    reg         overflow_r;
    wire [15:0] fifoData;
    wire        fifoValid;
    wire [4:0]  fifoLevel;
    wire        fifoPop;
    wire        wrGo;
    wire        wrHit;

    assign wrGo  = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrHit = (awIdx_r == `ASP_IDX_RATE) || (awIdx_r == `ASP_IDX_FMT) ||
                   (awIdx_r == `ASP_IDX_MODE) || (awIdx_r == `ASP_IDX_CTRL);

    // ------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            awHeld_r      <= 1'b0;
            wHeld_r       <= 1'b0;
            awIdx_r       <= 7'h00;
            wData_r       <= 32'h00000000;
            wStrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            rate_r        <= `ASP_RST_RATE;
            fmt_r         <= `ASP_RST_FMT;
            mode_r        <= `ASP_RST_MODE;
            ctrl_r        <= `ASP_RST_CTRL;
        end else begin
            s_axi_awready <= !awHeld_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awIdx_r  <= s_axi_awaddr[8:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (wrGo) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? 2'b00 : 2'b10;
                if (wStrb_r[0]) begin
                    case (awIdx_r)
                        `ASP_IDX_RATE: rate_r <= wData_r[7:0];
                        `ASP_IDX_FMT:  fmt_r  <= wData_r[7:0];
                        `ASP_IDX_MODE: mode_r <= wData_r[7:0];
                        `ASP_IDX_CTRL: ctrl_r <= wData_r[7:0];
                        default:       ctrl_r <= ctrl_r;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel; sample register read pops the fifo
    // ------------------------------------------------------------
    assign fifoPop = s_axi_arvalid && s_axi_arready &&
                     (s_axi_araddr[8:2] == `ASP_IDX_SAMPLE);

    always @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr[8:2])
                    `ASP_IDX_RATE:   s_axi_rdata <= {24'h000000, rate_r};
                    `ASP_IDX_FMT:    s_axi_rdata <= {24'h000000, fmt_r};
                    `ASP_IDX_MODE:   s_axi_rdata <= {24'h000000, mode_r};
                    `ASP_IDX_CTRL:   s_axi_rdata <= {24'h000000, ctrl_r};
                    `ASP_IDX_STAT:   s_axi_rdata <= {25'h0000000, overflow_r,
                                                     fifoValid, fifoLevel};
                    `ASP_IDX_SAMPLE: s_axi_rdata <= {fifoValid, 15'h0000, fifoData};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // master clock and derived bit clock / word select
    // ------------------------------------------------------------
    reg  [4:0] mclkDiv_r;
    reg        mclkPh_r;
    reg  [7:0] bclkDiv_r;
    reg  [5:0] slot_r;
    wire       mclkEn  = (mode_r[1:0] == `ASP_MCLK_ON);
    wire       mclkTick = (mclkDiv_r == `ASP_MCLK_HALF - 1);
    wire       isMaster = ctrl_r[`ASP_CTRL_RXMODE] || fmt_r[`ASP_FMT_MASTER];
    // one bit clock = 256 mclk periods = 512 mclk half periods
    wire       bclkHalf = mclkTick && (bclkDiv_r == 8'hff);
    wire       intBclk  = slot_r[0];
    wire [4:0] bitPos   = slot_r[5:1];

    always @(posedge clk) begin
        if (rst) begin
            mclkDiv_r <= 5'h00;
            mclkPh_r  <= 1'b0;
            bclkDiv_r <= 8'h00;
            slot_r    <= 6'h00;
        end else if (!mclkEn) begin
            mclkDiv_r <= 5'h00;
            mclkPh_r  <= 1'b0;
            bclkDiv_r <= 8'h00;
            slot_r    <= 6'h00;
        end else begin
            mclkDiv_r <= mclkTick ? 5'h00 : mclkDiv_r + 5'h01;
            if (mclkTick) begin
                mclkPh_r  <= !mclkPh_r;
                bclkDiv_r <= bclkDiv_r + 8'h01;
            end
            if (bclkHalf) begin
                slot_r <= slot_r + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [2:0] pinMeta_r;
    reg [2:0] pinSync_r;
    reg       bclkPrev_r;
    reg       wsPrev_r;
    reg       wsOutInt;
    wire      curBclk  = isMaster ? intBclk : pinSync_r[2];
    wire      curWs    = isMaster ? wsOutInt : pinSync_r[1];
    wire      bclkRise = curBclk && !bclkPrev_r;
    always @(posedge clk) begin
        if (rst) begin
            pinMeta_r  <= 3'h0;
            pinSync_r  <= 3'h0;
            bclkPrev_r <= 1'b0;
            wsPrev_r   <= 1'b0;
        end else begin
            pinMeta_r  <= {bitClkIn, wordSelIn, dataIn};
            pinSync_r  <= pinMeta_r;
            bclkPrev_r <= curBclk;
            if (bclkRise) begin
                wsPrev_r <= curWs;                           // ws as of the last rise
            end
        end
    end

    // ------------------------------------------------------------
    // capture: rising bit clock edge, msb per delay bit, mono select
    // ------------------------------------------------------------
    wire       leftNow  = (curWs == fmt_r[`ASP_FMT_WSPOL]);
    wire       wantSide = fmt_r[`ASP_FMT_RIGHT] ? !leftNow : leftNow;
    // left-justified forces zero delay; i2s forces one bit of delay; other codes use the delay bit
    wire       noDelay  = (fmt_r[3:0] == `ASP_FMT_LJ) ||
                          ((fmt_r[3:0] != `ASP_FMT_I2S) &&
                           fmt_r[`ASP_FMT_NODLY]);
    reg  [4:0] bitCnt_r;
    reg  [15:0] shift_r;
    reg        pending_r;
    reg        wsSeen_r;
    wire       fifoInReady;
    wire       capEn = !mode_r[`ASP_MODE_PDN] && !ctrl_r[`ASP_CTRL_RXMODE];

    always @* begin
        wsOutInt = fmt_r[`ASP_FMT_WSPOL];
        if (bitPos[4] == 1'b1) begin
            wsOutInt = !fmt_r[`ASP_FMT_WSPOL];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            bitCnt_r   <= 5'h00;
            shift_r    <= 16'h0000;
            pending_r  <= 1'b0;
            wsSeen_r   <= 1'b0;
            overflow_r <= 1'b0;
        end else begin
            if (pending_r && fifoInReady) begin
                pending_r <= 1'b0;
            end
            if (bclkRise && capEn) begin
                if (curWs != wsPrev_r) begin
                    wsSeen_r <= 1'b1;
                    bitCnt_r <= noDelay ? 5'h01 : 5'h00;
                    if (noDelay && wantSide) begin
                        shift_r <= {15'h0000, pinSync_r[0]};
                    end
                end else begin
                    if (bitCnt_r != 5'h1f) begin
                        bitCnt_r <= bitCnt_r + 5'h01;
                    end
                    // bitCnt_r is the index of the bit taken at this rise
                    if (wantSide && wsSeen_r && bitCnt_r <= 5'h0f) begin
                        shift_r <= {shift_r[14:0], pinSync_r[0]};
                    end
                    if (wantSide && wsSeen_r && bitCnt_r == 5'h0f) begin
                        if (pending_r && !fifoInReady) begin
                            overflow_r <= 1'b1;
                        end
                        pending_r <= 1'b1;
                    end
                end
            end
            if (wrGo && wStrb_r[0] && awIdx_r == `ASP_IDX_STAT &&
                wData_r[6] && !(pending_r && !fifoInReady)) begin
                overflow_r <= 1'b0;
            end
        end
    end

    asp_fifo #(
        .WIDTH (16),
        .DEPTH (16),
        .AW    (4)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (pending_r),
        .inReady  (fifoInReady),
        .inData   (shift_r),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData),
        .level    (fifoLevel)
    );

    // ------------------------------------------------------------
    // pin drivers and directions
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            bitClkOe_n  <= 1'b1;
            wordSelOe_n <= 1'b1;
            dataOe_n    <= 1'b1;
            mclkOe_n    <= 1'b1;
            bitClkOut   <= 1'b0;
            wordSelOut  <= 1'b0;
            dataOut     <= 1'b0;
            mclkOut     <= 1'b0;
            rfEnable    <= 1'b0;
            txPowerDown <= 1'b0;
        end else begin
            if (ctrl_r[`ASP_CTRL_CFGDONE]) begin
                mclkOe_n    <= 1'b0;
                bitClkOe_n  <= !isMaster;
                wordSelOe_n <= !isMaster;
                dataOe_n    <= !ctrl_r[`ASP_CTRL_RXMODE];
            end
            mclkOut     <= mclkPh_r;
            bitClkOut   <= intBclk;
            wordSelOut  <= wsOutInt;
            dataOut     <= 1'b0;
            rfEnable    <= mode_r[`ASP_MODE_RFEN];
            txPowerDown <= mode_r[`ASP_MODE_PDN];
        end
    end
endmodule // asp_serial_port

// File: test/asp_serial_port_sva.sv
// checker on the serial audio port pins and register bus
// assumes it is bound into asp_serial_port, one clock, sync reset
`timescale 1ns/10ps
module asp_serial_port_sva (
    input logic        clk,
    input logic        rst,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        bitClkOe_n,
    input logic        wordSelOe_n,
    input logic        dataOe_n,
    input logic        mclkOe_n,
    input logic        mclkOut
);
    logic [7:0] hiCnt;
    // length of the current mclk high phase
    always @(posedge clk) begin
        if (rst || !mclkOut) begin
            hiCnt <= 8'h00;
        end else begin
            hiCnt <= hiCnt + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_in;
        disable iff (1'b0) rst |=> bitClkOe_n && wordSelOe_n && dataOe_n && mclkOe_n;
    endproperty
    a_rst_in: assert property (p_rst_in) else $error("pin driven in reset");
    property p_rx_dir; !dataOe_n |-> !bitClkOe_n && !wordSelOe_n; endproperty
    a_rx_dir: assert property (p_rx_dir) else $error("data driven without clocks");
    property p_ws_dir; bitClkOe_n == wordSelOe_n; endproperty
    a_ws_dir: assert property (p_ws_dir) else $error("clock pins differ in direction");
    property p_mclk_dir; !bitClkOe_n || !dataOe_n |-> !mclkOe_n; endproperty
    a_mclk_dir: assert property (p_mclk_dir) else $error("mclk not driven");
    property p_mclk_half; hiCnt <= 8'd12; endproperty
    a_mclk_half: assert property (p_mclk_half) else $error("mclk high too long");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer not held");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_blat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_blat: assert property (p_blat) else $error("write answer late");
    property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_awpulse: assert property (p_awpulse) else $error("awready held");
    c_rd: cover property (s_axi_rvalid && s_axi_rready);
    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_rx: cover property ($fell(dataOe_n));
endmodule // asp_serial_port_sva

bind asp_serial_port asp_serial_port_sva asp_serial_port_sva_i (
    .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .bitClkOe_n(bitClkOe_n), .wordSelOe_n(wordSelOe_n), .dataOe_n(dataOe_n),
    .mclkOe_n(mclkOe_n), .mclkOut(mclkOut)
);

// File: test/asp_audio_src.sv
// slave-mode audio source, clocked from the device master clock
// assumes mclk comes from the device; frames run only while run is high
`timescale 1ns/10ps
module asp_audio_src #(
    parameter DIV = 256
) (
    input  logic        mclk,
    input  logic        run,
    input  logic        wsLeftHigh,
    input  logic        noDelay,
    input  logic [15:0] leftWord,
    input  logic [15:0] rightWord,
    output logic        bitClk = 1'b0,
    output logic        wordSel = 1'b0,
    output logic        data = 1'b0
);
    int cnt = 0;
    int pos = 0;
    int b;
    // bit clock divided from mclk, data changes on its falling edge
    always @(posedge mclk) begin
        if (!run) begin
            bitClk <= 1'b0;
            wordSel <= ~wordSel;
            data <= ~data;
        end else if (cnt >= DIV / 2 - 1) begin
            cnt <= 0;
            bitClk <= ~bitClk;
            if (bitClk) begin
                pos = (pos + 1) % 64;
                b = pos % 32 - (noDelay ? 0 : 1);
                wordSel <= (pos < 32) ? wsLeftHigh : !wsLeftHigh;
                data <= (b < 0 || b > 15) ? 1'b0 : (pos < 32) ? leftWord[15 - b] : rightWord[15 - b];
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // asp_audio_src

// File: test/asp_serial_port_tb_top.sv
// self-checking bench of the serial audio port
// assumes the slave-mode source model and the bound checker
`timescale 1ns/10ps
`include "asp_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errorCnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module asp_serial_port_tb_top;
    logic        clk, rst = 1'b1, run = 1'b0, wsHi = 1'b0, noDly = 1'b0;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [8:0]  awAddr = 9'h000, arAddr = 9'h000;
    logic [31:0] wData = 32'h0, rd, rData;
    logic [1:0]  rs, bRs, bResp, rResp;
    logic [15:0] leftW = 16'ha5c3, rightW = 16'h3c5a;
    logic        awReady, wReady, bValid, arReady, rValid, srcClk, srcWs, srcData;
    logic        bitClkOut, bitClkOe_n, wordSelOut, wordSelOe_n, dataOut, dataOe_n;
    logic        mclkOut, mclkOe_n, rfEnable, txPowerDown;
    wire  [3:0]  oeAll = {bitClkOe_n, wordSelOe_n, dataOe_n, mclkOe_n};
    int          errorCnt = 0, checked = 0;
    asp_serial_port asp_serial_port_i (
        .clk(clk), .rst(rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .bitClkIn(bitClkOe_n ? srcClk : bitClkOut), .bitClkOut(bitClkOut),
        .bitClkOe_n(bitClkOe_n), .wordSelIn(wordSelOe_n ? srcWs : wordSelOut),
        .wordSelOut(wordSelOut), .wordSelOe_n(wordSelOe_n),
        .dataIn(dataOe_n ? srcData : dataOut), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .mclkOut(mclkOut), .mclkOe_n(mclkOe_n), .rfEnable(rfEnable), .txPowerDown(txPowerDown)
    );
    asp_audio_src #(.DIV(2)) asp_audio_src_i (
        .mclk(mclkOut), .run(run), .wsLeftHigh(wsHi), .noDelay(noDly), .leftWord(leftW),
        .rightWord(rightW), .bitClk(srcClk), .wordSel(srcWs), .data(srcData)
    );
    task end_sim;
        if (errorCnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic hang(input logic b);
        if (b) begin
            errorCnt++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic busy = 1'b1;
        awAddr <= a;
        wData <= {24'h0, d};
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        repeat (100) begin
            if (busy) begin
                @(posedge clk);
                if (awReady) awValid <= 1'b0;
                if (wReady) wValid <= 1'b0;
                if (bValid) begin
                    bReady <= 1'b0;
                    busy = 1'b0;
                    bRs = bResp;
                end
            end
        end
        @(posedge clk);
        hang(busy);
    endtask
    task automatic rd_reg(input logic [8:0] a);
        logic busy = 1'b1;
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        repeat (100) begin
            if (busy) begin
                @(posedge clk);
                if (arReady) arValid <= 1'b0;
                if (rValid) begin
                    rReady <= 1'b0;
                    busy = 1'b0;
                    rd = rData;
                    rs = rResp;
                end
            end
        end
        @(posedge clk);
        hang(busy);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        repeat (2) @(posedge clk);
        `CHK(oeAll, 4'hf)
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic t_regs;
        logic [8:0] a [3] = '{9'h004, 9'h150, 9'h168};
        logic [7:0] e [3] = '{8'h50, 8'h80, 8'h03};
        for (int i = 0; i < 3; i++) begin
            rd_reg(a[i]);
            `CHK(rd, {24'h0, e[i]})
        end
        rd_reg(9'h008);
        `CHK({rs, rd}, {2'b10, 32'h0})
        wr(9'h008, 8'h11);
        `CHK(bRs, 2'b10)
        wr(9'h004, 8'h50);
        rd_reg(9'h004);
        `CHK({rs, rd[7:0]}, {2'b00, 8'h50})
    endtask
    task automatic t_mclk;
        logic [7:0] m [3] = '{8'h00, 8'hc3, 8'h03};
        int hi;
        for (int i = 0; i < 3; i++) begin
            wr(9'h168, m[i]);
            repeat (30) @(posedge clk);
            hi = 0;
            repeat (20 * `ASP_MCLK_HALF) begin
                @(posedge clk);
                hi += (mclkOut === 1'b1);
            end
            `CHK(hi, (m[i] == 8'h00) ? 0 : 10 * `ASP_MCLK_HALF)
            `CHK({rfEnable, txPowerDown}, m[i][7:6])
        end
    endtask
    task automatic t_dirs;
        logic [7:0] f [3] = '{8'h80, 8'h80, 8'h00};
        logic [7:0] c [3] = '{8'h02, 8'h03, 8'h02};
        logic [3:0] e [3] = '{4'h2, 4'h0, 4'he};
        int         hi;
        wr(9'h150, 8'h80);
        repeat (4) @(posedge clk);
        `CHK(oeAll, 4'hf)
        for (int i = 0; i < 3; i++) begin
            wr(9'h150, f[i]);
            wr(9'h1c0, c[i]);
            repeat (4) @(posedge clk);
            `CHK(oeAll, e[i])
            if (i == 1) begin
                // one full bit clock period: high for half of it
                hi = 0;
                repeat (2 * `ASP_MCLK_RATIO * `ASP_MCLK_HALF) begin
                    @(posedge clk);
                    hi += (bitClkOut === 1'b1);
                end
                `CHK(hi, `ASP_MCLK_RATIO * `ASP_MCLK_HALF)
            end
        end
        // reset in mid-run while the mclk pin is driven
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(oeAll, 4'hf)
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(oeAll, 4'hf)
    endtask
    task automatic t_cap(input logic [7:0] f, input logic pol, input logic nd,
                         input logic [15:0] w);
        int n = 0;
        wr(9'h150, f);
        wsHi <= pol;
        noDly <= nd;
        run <= 1'b1;
        repeat (7000) @(posedge clk);
        repeat (20) rd_reg(9'h1c8);
        rd = 32'h0;
        while (rd[31] !== 1'b1 && n < 1500) begin
            rd_reg(9'h1c8);
            n++;
        end
        `CHK({rd[31], rd[15:0]}, {1'b1, w})
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        t_reset();
        t_regs();
        t_mclk();
        t_dirs();
        t_cap(8'h00, 1'b0, 1'b0, leftW);
        t_cap(8'h1a, 1'b1, 1'b1, rightW);
        end_sim();
    end
endmodule // asp_serial_port_tb_top
